// >>> verilog/dams_mode_seq.sv
// mode register and sequencing for the main and side converters
//
// Overview of operation
// (RQ1) 8-bit mode register at D1H, reset 00H
// (RQ2) bit 5 enables main converter, else down
// (RQ3) bit 4 enables side converter, else down
// (RQ4) bits 2..0 select one of eight modes
// (RQ5) idle holds filter, modulator reset, clocks run
// (RQ6) single conversion updates results, returns to 000
// (RQ7) continuous mode updates results at decimation rate
// (RQ8) internal zero-scale routes internal short to inputs
// (RQ9) internal full-scale routes selected reference to inputs
// (RQ10) outside applies system calibration input to channels
// (RQ11) any mode field write resets both converters
// (RQ12) main config write or main enable resets both; a config write resets only while main is enabled
// (RQ13) side config write or enable resets side only; an enable comes by mode write, which resets both
// (RQ14) side aligns to main, up to three outputs
// (RQ15) calibration write clears both ready flags, starts
// (RQ16) calibration end writes coefficients, flags, mode 000
// (RQ17) side calibration on temperature sensor fails, flags error
// (RQ18) calibrations run at maximum decimation ratio
// (RQ19) set ready flag blocks further result writes
// (RQ20) calibration done set at end, cleared by write
// (RQ21) disabled converter ignores mode, stays powered down
`timescale 1ns/1ps

module dams_mode_seq
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // special function register bus
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    // configuration bits held in the converter config registers
    input wire logic main_ref_select,
    input wire logic side_ref_select,
    input wire logic [1:0] side_channel_select,
    // filter completion and software clears of the ready flags
    input wire logic main_filter_done,
    input wire logic side_filter_done,
    input wire logic main_ready_clr,
    input wire logic side_ready_clr,
    // main converter control
    output logic main_pwr_down,
    output logic main_mod_reset,
    output logic main_filt_reset,
    output logic main_mod_clk_en,
    output logic [1:0] main_input_route,
    output logic main_ref_ext,
    // side converter control
    output logic side_pwr_down,
    output logic side_mod_reset,
    output logic side_filt_reset,
    output logic side_mod_clk_en,
    output logic [1:0] side_input_route,
    output logic side_ref_ext,
    // shared filter control
    output logic decim_force_max,
    // write strobes for result and coefficient registers
    output logic main_result_we,
    output logic main_cal_we,
    output logic side_result_we,
    output logic side_cal_we,
    // status flags
    output logic main_result_ready,
    output logic side_result_ready,
    output logic side_error_flag,
    output logic cal_done
);
    import dams_pkg::*;

    // true for the four calibration codes
    function automatic logic dams_is_cal(input logic [2:0] md);
        dams_is_cal = md[2];
    endfunction

    // true for modes that run the converter and produce outputs
    function automatic logic dams_runs(input logic [2:0] md);
        dams_runs = (md == DAMS_MD_SINGLE) | (md == DAMS_MD_CONT)
            | dams_is_cal(md);
    endfunction

    // route for a given mode field value
    function automatic logic [1:0] dams_route(input logic [2:0] md);
        if (md == DAMS_MD_INT_ZERO)
            dams_route = DAMS_ROUTE_SHORT;
        else if (md == DAMS_MD_INT_FULL)
            dams_route = DAMS_ROUTE_REF;
        else
            dams_route = DAMS_ROUTE_CHAN;
    endfunction

    // mode register state
    logic main_en_q;
    logic side_en_q;
    logic [2:0] op_mode_field_q;
    logic [2:0] op_mode_field_d;
    logic main_en_d;
    logic side_en_d;

    // run bookkeeping
    logic main_got_q;
    logic side_got_q;
    logic cal_done_q;
    logic cal_done_d;
    logic [1:0] align_q;
    logic [1:0] align_d;

    // registered control outputs
    logic main_pwr_down_q;
    logic main_mod_reset_q;
    logic main_filt_reset_q;
    logic main_mod_clk_en_q;
    logic [1:0] main_route_q;
    logic main_ref_ext_q;
    logic side_pwr_down_q;
    logic side_mod_reset_q;
    logic side_filt_reset_q;
    logic side_mod_clk_en_q;
    logic [1:0] side_route_q;
    logic side_ref_ext_q;
    logic decim_max_q;
    logic [7:0] rdata_q;

    // bus decode
    logic mode_wr;
    logic main_cfg_wr;
    logic side_cfg_wr;
    logic mode_rd;
    assign mode_wr = sfr_wr & (sfr_addr == DAMS_MODE_ADDR); // [RQ1]
    assign main_cfg_wr = sfr_wr & (sfr_addr == DAMS_MAIN_CFG_ADDR);
    assign side_cfg_wr = sfr_wr & (sfr_addr == DAMS_SIDE_CFG_ADDR);
    assign mode_rd = sfr_rd & (sfr_addr == DAMS_MODE_ADDR);

    // reset requests; main changes take priority and hit both converters
    logic main_en_rise;
    logic side_en_rise;
    logic rst_both;
    logic rst_side;
    assign main_en_rise = mode_wr & sfr_wdata[DAMS_MAIN_EN_BIT] & ~main_en_q;
    assign side_en_rise = mode_wr & sfr_wdata[DAMS_SIDE_EN_BIT] & ~side_en_q;
    assign rst_both = mode_wr // [RQ11]
        | (main_cfg_wr & main_en_q) | main_en_rise; // [RQ12]
    assign rst_side = rst_both | side_cfg_wr | side_en_rise; // [RQ13]

    // per converter activity; a disabled converter ignores the mode
    logic main_active;
    logic side_active;
    logic run_cal;
    logic side_cal_fail;
    assign main_active = main_en_q & dams_runs(op_mode_field_q) // [RQ2]
        & ~rst_both; // [RQ21]
    assign side_active = side_en_q & dams_runs(op_mode_field_q) // [RQ3]
        & ~rst_side; // [RQ21]
    assign run_cal = dams_is_cal(op_mode_field_q);
    assign side_cal_fail = (side_channel_select == DAMS_SIDE_TEMP_CH); // [RQ17]

    // side waits for main outputs after a reset that spared the main
    logic side_hold;
    logic main_running;
    assign main_running = main_en_q & dams_runs(op_mode_field_q);
    assign side_hold = (align_q != 2'h0);

    // a mode write that starts work clears ready, error and cal done
    logic start_wr;
    assign start_wr = mode_wr
        & dams_runs(sfr_wdata[DAMS_MODE_LSB +: DAMS_MODE_W]);

    logic main_accept;
    logic side_accept;

    // main converter flag and strobe control
    dams_conv_chan u_main
    (
        .clock(clock),
        .rst_b(rst_b),
        .active(main_active),
        .is_cal(run_cal),
        .cal_fail(1'b0),
        .hold_off(1'b0),
        .mode_clr(start_wr), // [RQ15]
        .done_in(main_filter_done),
        .ready_clr(main_ready_clr),
        .ready_q(main_result_ready),
        .err_q(),
        .result_we_q(main_result_we),
        .cal_we_q(main_cal_we),
        .accept_q(main_accept)
    );

    // side converter flag and strobe control
    dams_conv_chan u_side
    (
        .clock(clock),
        .rst_b(rst_b),
        .active(side_active),
        .is_cal(run_cal),
        .cal_fail(side_cal_fail),
        .hold_off(side_hold), // [RQ14]
        .mode_clr(start_wr), // [RQ15]
        .done_in(side_filter_done),
        .ready_clr(side_ready_clr),
        .ready_q(side_result_ready),
        .err_q(side_error_flag),
        .result_we_q(side_result_we),
        .cal_we_q(side_cal_we),
        .accept_q(side_accept)
    );

    // run completes once every enabled converter has given its output;
    // accept pulses lag one cycle, so a fresh mode write always masks them
    logic main_fin;
    logic side_fin;
    logic oneshot;
    logic run_end;
    assign main_fin = ~main_en_q | main_got_q | main_accept;
    assign side_fin = ~side_en_q | side_got_q | side_accept;
    assign oneshot = (op_mode_field_q == DAMS_MD_SINGLE) | run_cal;
    assign run_end = oneshot & (main_en_q | side_en_q)
        & main_fin & side_fin & ~mode_wr;

    // next mode value: software write wins, else hardware return to 000
    always_comb
    begin
        main_en_d = main_en_q;
        side_en_d = side_en_q;
        op_mode_field_d = op_mode_field_q;
        if (mode_wr)
        begin
            main_en_d = sfr_wdata[DAMS_MAIN_EN_BIT]; // [RQ2]
            side_en_d = sfr_wdata[DAMS_SIDE_EN_BIT]; // [RQ3]
            op_mode_field_d = sfr_wdata[DAMS_MODE_LSB +: DAMS_MODE_W]; // [RQ4]
        end
        else if (run_end)
            op_mode_field_d = DAMS_MD_PWRDN; // [RQ6] [RQ16]
    end

    // calibration done: set at calibration end wins over a clear
    assign cal_done_d = (run_end & run_cal) // [RQ20]
        | (cal_done_q & ~start_wr);

    // alignment count: loaded on a side-only reset with main running
    always_comb
    begin
        align_d = align_q;
        if (rst_both)
            align_d = 2'h0;
        else if (rst_side && main_running)
            align_d = DAMS_ALIGN_OUTPUTS; // [RQ14]
        else if (side_hold && main_filter_done)
            align_d = align_q - 2'h1;
    end

    // mode register and run bookkeeping
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            main_en_q <= DAMS_MODE_RESET[DAMS_MAIN_EN_BIT]; // [RQ1]
            side_en_q <= DAMS_MODE_RESET[DAMS_SIDE_EN_BIT];
            op_mode_field_q <= DAMS_MODE_RESET[DAMS_MODE_LSB +: DAMS_MODE_W];
            main_got_q <= 1'b0;
            side_got_q <= 1'b0;
            cal_done_q <= 1'b0;
            align_q <= 2'h0;
        end
        else
        begin
            main_en_q <= main_en_d;
            side_en_q <= side_en_d;
            op_mode_field_q <= op_mode_field_d;
            main_got_q <= ~rst_both & ~run_end & (main_got_q | main_accept);
            side_got_q <= ~rst_side & ~run_end & (side_got_q | side_accept);
            cal_done_q <= cal_done_d;
            align_q <= align_d;
        end
    end

    // converter control next values
    logic main_on;
    logic side_on;
    logic idle_md;
    assign main_on = main_en_d & (op_mode_field_d != DAMS_MD_PWRDN);
    assign side_on = side_en_d & (op_mode_field_d != DAMS_MD_PWRDN);
    assign idle_md = (op_mode_field_d == DAMS_MD_IDLE);

    // a disabled converter keeps its inputs on the channel pins
    logic [2:0] main_md;
    logic [2:0] side_md;
    assign main_md = op_mode_field_d & {3{main_on}}; // [RQ21]
    assign side_md = op_mode_field_d & {3{side_on}}; // [RQ21]

    // converter control registers; idle keeps clocks while in reset
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            main_pwr_down_q <= 1'b1;
            main_mod_reset_q <= 1'b1;
            main_filt_reset_q <= 1'b1;
            main_mod_clk_en_q <= 1'b0;
            main_route_q <= DAMS_ROUTE_CHAN;
            main_ref_ext_q <= 1'b0;
            side_pwr_down_q <= 1'b1;
            side_mod_reset_q <= 1'b1;
            side_filt_reset_q <= 1'b1;
            side_mod_clk_en_q <= 1'b0;
            side_route_q <= DAMS_ROUTE_CHAN;
            side_ref_ext_q <= 1'b0;
            decim_max_q <= 1'b0;
        end
        else
        begin
            main_pwr_down_q <= ~main_on; // [RQ2] [RQ21]
            main_mod_reset_q <= ~main_on | idle_md | rst_both; // [RQ5]
            main_filt_reset_q <= ~main_on | idle_md | rst_both; // [RQ5]
            main_mod_clk_en_q <= main_on; // [RQ5]
            main_route_q <= dams_route(main_md); // [RQ8] [RQ9]
            main_ref_ext_q <= main_ref_select; // [RQ9]
            side_pwr_down_q <= ~side_on; // [RQ3] [RQ21]
            side_mod_reset_q <= ~side_on | idle_md | rst_side; // [RQ5]
            side_filt_reset_q <= ~side_on | idle_md | rst_side; // [RQ5]
            side_mod_clk_en_q <= side_on; // [RQ5]
            side_route_q <= dams_route(side_md); // [RQ8] [RQ9]
            side_ref_ext_q <= side_ref_select; // [RQ9]
            decim_max_q <= dams_is_cal(op_mode_field_d); // [RQ18]
        end
    end

    // read port: reserved bits 7, 6 and 3 read as zero
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            rdata_q <= 8'h00;
        else if (mode_rd)
            rdata_q <= {2'h0, main_en_q, side_en_q, 1'b0,
                op_mode_field_q}; // [RQ1]
        else
            rdata_q <= 8'h00;
    end

    // outputs straight from flops
    assign sfr_rdata = rdata_q;
    assign main_pwr_down = main_pwr_down_q;
    assign main_mod_reset = main_mod_reset_q;
    assign main_filt_reset = main_filt_reset_q;
    assign main_mod_clk_en = main_mod_clk_en_q;
    assign main_input_route = main_route_q;
    assign main_ref_ext = main_ref_ext_q;
    assign side_pwr_down = side_pwr_down_q;
    assign side_mod_reset = side_mod_reset_q;
    assign side_filt_reset = side_filt_reset_q;
    assign side_mod_clk_en = side_mod_clk_en_q;
    assign side_input_route = side_route_q;
    assign side_ref_ext = side_ref_ext_q;
    assign decim_force_max = decim_max_q;
    assign cal_done = cal_done_q;

endmodule // dams_mode_seq

// >>> verilog/dams_pkg.sv
// shared constants for the dual converter mode sequencer
package dams_pkg;

    // special function addresses seen on the core bus
    localparam logic [7:0] DAMS_MODE_ADDR = 8'hd1;
    localparam logic [7:0] DAMS_MAIN_CFG_ADDR = 8'hd2;
    localparam logic [7:0] DAMS_SIDE_CFG_ADDR = 8'hd3;

    // mode register value after reset and its field positions
    localparam logic [7:0] DAMS_MODE_RESET = 8'h00;
    localparam int DAMS_MAIN_EN_BIT = 5;
    localparam int DAMS_SIDE_EN_BIT = 4;
    localparam int DAMS_MODE_LSB = 0;
    localparam int DAMS_MODE_W = 3;

    // operating mode field codes
    localparam logic [2:0] DAMS_MD_PWRDN = 3'h0;
    localparam logic [2:0] DAMS_MD_IDLE = 3'h1;
    localparam logic [2:0] DAMS_MD_SINGLE = 3'h2;
    localparam logic [2:0] DAMS_MD_CONT = 3'h3;
    localparam logic [2:0] DAMS_MD_INT_ZERO = 3'h4;
    localparam logic [2:0] DAMS_MD_INT_FULL = 3'h5;
    localparam logic [2:0] DAMS_MD_SYS_ZERO = 3'h6;
    localparam logic [2:0] DAMS_MD_SYS_FULL = 3'h7;

    // input routing codes driven to the analog multiplexer
    localparam logic [1:0] DAMS_ROUTE_CHAN = 2'h0;
    localparam logic [1:0] DAMS_ROUTE_SHORT = 2'h1;
    localparam logic [1:0] DAMS_ROUTE_REF = 2'h2;

    // side channel code that selects the temperature sensor
    localparam logic [1:0] DAMS_SIDE_TEMP_CH = 2'h2;

    // main outputs a side converter may wait for after its own reset
    localparam logic [1:0] DAMS_ALIGN_OUTPUTS = 2'h3;

endpackage

// >>> verilog/dams_conv_chan.sv
// per-converter ready, error and result write control
`timescale 1ns/1ps

module dams_conv_chan
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // sequencer view
    input wire logic active,
    input wire logic is_cal,
    input wire logic cal_fail,
    input wire logic hold_off,
    input wire logic mode_clr,
    // filter and software
    input wire logic done_in,
    input wire logic ready_clr,
    // flags and strobes
    output logic ready_q,
    output logic err_q,
    output logic result_we_q,
    output logic cal_we_q,
    output logic accept_q
);

    logic accept;
    logic ready_d;
    logic err_d;

    // a result is taken only while ready is low and alignment is over
    assign accept = active & done_in & ~ready_q & ~hold_off; // [RQ19] [RQ21]
    // set wins over a clear that lands in the same cycle
    assign ready_d = accept | (ready_q & ~ready_clr & ~mode_clr); // [RQ15]
    assign err_d = (accept & is_cal & cal_fail) | (err_q & ~mode_clr); // [RQ17]

    // flags and one-cycle write strobes
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            ready_q <= 1'b0;
            err_q <= 1'b0;
            result_we_q <= 1'b0;
            cal_we_q <= 1'b0;
            accept_q <= 1'b0;
        end
        else
        begin
            ready_q <= ready_d;
            err_q <= err_d;
            result_we_q <= accept & ~is_cal; // [RQ6] [RQ7]
            cal_we_q <= accept & is_cal & ~cal_fail; // [RQ16] [RQ17]
            accept_q <= accept;
        end
    end

endmodule // dams_conv_chan

// >>> testbench/dams_mode_seq_properties.sv
// concurrent checks on the mode sequencer ports
`timescale 1ns/1ps

module dams_mode_seq_properties
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // register bus
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata,
    // converter control
    input wire logic main_pwr_down,
    input wire logic main_mod_reset,
    input wire logic main_filt_reset,
    input wire logic main_mod_clk_en,
    input wire logic [1:0] main_input_route,
    input wire logic side_mod_reset,
    input wire logic side_filt_reset,
    input wire logic decim_force_max,
    // strobes and flags
    input wire logic main_result_we,
    input wire logic main_cal_we,
    input wire logic side_result_we,
    input wire logic side_cal_we,
    input wire logic main_result_ready,
    input wire logic side_result_ready,
    input wire logic side_error_flag,
    input wire logic cal_done
);
    import dams_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    // reset windows; one spare cycle allowed for the registered pulse
    sequence both_rst;
        main_mod_reset && main_filt_reset && side_mod_reset && side_filt_reset;
    endsequence
    sequence side_rst;
        side_mod_reset && side_filt_reset;
    endsequence
    // read path
    chk_rsvd_zero: assert property
        (sfr_rdata[7:6] == 2'h0 && !sfr_rdata[3]) else $error("reserved bit set");
    chk_read_src: assert property
        (sfr_rdata != 8'h00 |-> $past(sfr_rd && sfr_addr == DAMS_MODE_ADDR))
        else $error("read data without mode read");
    // resynchronisation after writes
    chk_mode_reset: assert property
        (sfr_wr && sfr_addr == DAMS_MODE_ADDR |=> ##[0:1] both_rst)
        else $error("mode write did not reset both");
    chk_main_cfg: assert property
        (sfr_wr && sfr_addr == DAMS_MAIN_CFG_ADDR && !main_pwr_down
        |=> ##[0:1] both_rst) else $error("main config write missed reset");
    chk_side_cfg: assert property
        (sfr_wr && sfr_addr == DAMS_SIDE_CFG_ADDR |=> ##[0:1] side_rst)
        else $error("side config write missed reset");
    // main power-down holds the modulator in reset and stops its clock
    chk_pwr_hold: assert property
        (main_pwr_down |-> main_mod_reset && !main_mod_clk_en)
        else $error("powered down main still clocked");
    // a standing ready flag blocks further writes
    chk_main_block: assert property
        (main_result_we || main_cal_we |-> !$past(main_result_ready)
        && main_result_ready) else $error("main write while ready");
    chk_side_block: assert property
        (side_result_we || side_cal_we |-> !$past(side_result_ready)
        && side_result_ready) else $error("side write while ready");
    // calibration bookkeeping
    chk_cal_flag: assert property
        ($rose(cal_done) |-> $past(main_cal_we || side_cal_we
        || side_error_flag))
        else $error("calibration done without calibration end");
    chk_cal_ratio: assert property
        (main_input_route != DAMS_ROUTE_CHAN |-> decim_force_max)
        else $error("calibration not at max ratio");
    chk_temp_fail: assert property
        ($rose(side_error_flag) |-> side_result_ready && !side_cal_we)
        else $error("temperature calibration wrote coefficients");
endmodule // dams_mode_seq_properties

bind dams_mode_seq dams_mode_seq_properties u_props
(
    .clock(clock), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .main_pwr_down(main_pwr_down),
    .main_mod_reset(main_mod_reset), .main_filt_reset(main_filt_reset),
    .main_mod_clk_en(main_mod_clk_en), .main_input_route(main_input_route),
    .side_mod_reset(side_mod_reset), .side_filt_reset(side_filt_reset),
    .decim_force_max(decim_force_max), .main_result_we(main_result_we),
    .main_cal_we(main_cal_we), .side_result_we(side_result_we),
    .side_cal_we(side_cal_we), .main_result_ready(main_result_ready),
    .side_result_ready(side_result_ready),
    .side_error_flag(side_error_flag), .cal_done(cal_done)
);

// >>> testbench/testbench.sv
// self-checking bench for the dual converter mode sequencer
`timescale 1ns/1ps

module testbench;
    import dams_pkg::*;
    // stimulus valued at time zero; captured rd, rs and got left unset
    logic clock = 1'b0, rst_b = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, rd;
    logic mrs = 1'b0, srs = 1'b0, mfd = 1'b0, sfd = 1'b0;
    logic mrc = 1'b0, src = 1'b0;
    logic [1:0] s_ch = 2'h0, rs;
    logic [3:0] got;
    int bad_count = 0, compares = 0;
    // design outputs
    logic [7:0] sfr_rdata;
    logic [1:0] m_rt, s_rt;
    logic m_pd, m_mr, m_fr, m_ce, m_rx, s_pd, s_mr, s_fr, s_ce, s_rx, dfm;
    logic mrw, mcw, srw, scw, mry, sry, serr, cdn;
    // packed views keep each comparison to one call
    wire [7:0] mctl = {m_pd, m_mr, m_fr, m_ce, m_rt, m_rx, dfm};
    wire [7:0] sctl = {s_pd, s_mr, s_fr, s_ce, s_rt, s_rx, dfm};
    wire [7:0] flg = {mry, sry, serr, cdn, 4'h0};
    wire [3:0] stb = {mrw, mcw, srw, scw};

    dams_mode_seq u_dut
    (
        .clock(clock), .rst_b(rst_b), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .main_ref_select(mrs), .side_ref_select(srs),
        .side_channel_select(s_ch), .main_filter_done(mfd),
        .side_filter_done(sfd), .main_ready_clr(mrc), .side_ready_clr(src),
        .main_pwr_down(m_pd), .main_mod_reset(m_mr), .main_filt_reset(m_fr),
        .main_mod_clk_en(m_ce), .main_input_route(m_rt), .main_ref_ext(m_rx),
        .side_pwr_down(s_pd), .side_mod_reset(s_mr), .side_filt_reset(s_fr),
        .side_mod_clk_en(s_ce), .side_input_route(s_rt), .side_ref_ext(s_rx),
        .decim_force_max(dfm), .main_result_we(mrw), .main_cal_we(mcw),
        .side_result_we(srw), .side_cal_we(scw), .main_result_ready(mry),
        .side_result_ready(sry), .side_error_flag(serr), .cal_done(cdn)
    );

    // 250 MHz core clock
    initial
    begin
        forever #2 clock = ~clock;
    end

    task check(input string n, input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    // one bus cycle; strobe held across exactly one sampling edge
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = w;
        sfr_rd = !w;
        @(posedge clock);
        #1;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        rd = sfr_rdata;
    endtask

    // one-cycle filter done and ready clears; strobes caught over two cycles
    task pulse(input logic md, input logic sd, input logic mc, input logic sc);
        @(posedge clock);
        #1;
        {mfd, sfd, mrc, src} = {md, sd, mc, sc};
        @(posedge clock);
        #1;
        {mfd, sfd, mrc, src} = 4'h0;
        got = stb;
        @(posedge clock);
        #1;
        got = got | stb;
    endtask

    // collects which converters saw a reset just after a write
    task watch;
        rs = {m_mr, s_mr};
        repeat (2)
        begin
            @(posedge clock);
            #1;
            rs = rs | {m_mr, s_mr};
        end
    endtask

    task t_modes;
        logic [7:0] tbl [8];
        tbl = '{8'he0, 8'h70, 8'h10, 8'h10, 8'h15, 8'h19, 8'h11, 8'h11};
        check("main ctl", mctl, 8'he0);
        check("side ctl", sctl, 8'he0);
        bus(1'b0, DAMS_MODE_ADDR, 8'h00);
        check("mode rd", rd, DAMS_MODE_RESET);
        for (int c = 0; c < 8; c++)
        begin
            bus(1'b1, DAMS_MODE_ADDR, 8'h20 | 8'(c));
            bus(1'b0, DAMS_MODE_ADDR, 8'h00);
            check("mode rd", rd, 8'h20 | 8'(c));
            check("main ctl", mctl, tbl[c]);
            check("side ctl", sctl, (c >= 4) ? 8'he1 : 8'he0);
        end
        bus(1'b1, DAMS_MODE_ADDR, 8'hff);
        bus(1'b0, DAMS_MODE_ADDR, 8'h00);
        check("mode rd", rd, 8'h37);
        check("side ctl", sctl, 8'h11);
        bus(1'b0, DAMS_MAIN_CFG_ADDR, 8'h00);
        check("cfg rd", rd, 8'h00);
    endtask

    task t_single;
        bus(1'b1, DAMS_MODE_ADDR, 8'h22);
        pulse(1'b1, 1'b1, 1'b0, 1'b0);
        check("strobes", {4'h0, got}, 8'h08);
        check("flags", flg, 8'h80);
        bus(1'b0, DAMS_MODE_ADDR, 8'h00);
        check("mode rd", rd, 8'h20);
        check("main ctl", mctl, 8'he0);
    endtask

    task t_cont;
        bus(1'b1, DAMS_MODE_ADDR, 8'h33);
        pulse(1'b1, 1'b1, 1'b0, 1'b0);
        check("strobes", {4'h0, got}, 8'h0a);
        pulse(1'b1, 1'b1, 1'b0, 1'b0);
        check("strobes", {4'h0, got}, 8'h00);
        pulse(1'b0, 1'b0, 1'b1, 1'b0);
        pulse(1'b1, 1'b0, 1'b0, 1'b0);
        check("strobes", {4'h0, got}, 8'h08);
        pulse(1'b0, 1'b0, 1'b0, 1'b1);
        bus(1'b1, DAMS_SIDE_CFG_ADDR, 8'h00);
        watch;
        check("resets", {6'h0, rs}, 8'h01);
        pulse(1'b0, 1'b1, 1'b0, 1'b0);
        check("strobes", {4'h0, got}, 8'h00);
        repeat (3) pulse(1'b1, 1'b0, 1'b0, 1'b0);
        pulse(1'b0, 1'b1, 1'b0, 1'b0);
        check("strobes", {4'h0, got}, 8'h02);
        bus(1'b1, DAMS_MAIN_CFG_ADDR, 8'h07);
        watch;
        check("resets", {6'h0, rs}, 8'h03);
        bus(1'b1, DAMS_MODE_ADDR, 8'h33);
        watch;
        check("resets", {6'h0, rs}, 8'h03);
        bus(1'b0, DAMS_MODE_ADDR, 8'h00);
        check("mode rd", rd, 8'h33);
    endtask

    // calibrations: routing, flags, coefficient writes, failed side case
    task t_cal;
        mrs = 1'b1;
        srs = 1'b1;
        bus(1'b1, DAMS_MODE_ADDR, 8'h35);
        watch;
        check("flags", flg, 8'h00);
        check("main ctl", mctl, 8'h1b);
        check("side ctl", sctl, 8'h1b);
        pulse(1'b1, 1'b1, 1'b0, 1'b0);
        check("strobes", {4'h0, got}, 8'h05);
        check("flags", flg, 8'hd0);
        bus(1'b0, DAMS_MODE_ADDR, 8'h00);
        check("mode rd", rd, 8'h30);
        bus(1'b1, DAMS_MODE_ADDR, 8'h34);
        watch;
        check("flags", flg, 8'h00);
        check("main ctl", mctl, 8'h17);
        s_ch = DAMS_SIDE_TEMP_CH;
        bus(1'b1, DAMS_MODE_ADDR, 8'h14);
        pulse(1'b0, 1'b1, 1'b0, 1'b0);
        check("strobes", {4'h0, got}, 8'h00);
        check("flags", flg & 8'he0, 8'h60);
    endtask

    // reset with flags standing after the last run ended returns everything to power-down
    task t_reset;
        @(posedge clock);
        #1;
        rst_b = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        rst_b = 1'b1;
        check("flags", flg, 8'h00);
        check("side ctl", sctl, 8'he0);
        bus(1'b0, DAMS_MODE_ADDR, 8'h00);
        check("mode rd", rd, DAMS_MODE_RESET);
    endtask

    task results;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge clock);
        #1;
        rst_b = 1'b1;
        t_modes;
        t_single;
        t_cont;
        t_cal;
        t_reset;
        results;
    end

    // the sequence needs well under a thousand cycles
    initial
    begin
        #20000;
        bad_count++;
        results;
    end
endmodule // testbench
